/* awr_pkg.sv */
// Purpose: constants shared by the word-rate, filter and clock-select control block
// Assumes: pclk at 100 MHz, APB register access, 32-bit data
// Notes: all offsets are byte addresses of aligned words
package awr_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONV_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WORD_RATE = 8'h04;
    localparam logic [7:0] ADDR_MUX_SEL = 8'h08;
    localparam logic [7:0] ADDR_GAIN_SEL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DATA = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // ----------------------------------------------------------------
    // fields and codes
    // ----------------------------------------------------------------
    localparam int CONV_W = 2;
    localparam logic [1:0] CONV_IDLE = 2'h0;
    localparam logic [1:0] CONV_SINGLE = 2'h1;
    localparam logic [1:0] CONV_CONT = 2'h2;
    localparam int RATE_W = 5;
    localparam logic [4:0] RATE_RST = 5'h00;
    localparam logic [4:0] RATE_MAX_CODE = 5'h13;
    localparam int MUX_W = 3;
    localparam int GAIN_W = 3;
    localparam int WORD_W = 24;
    localparam int IRQ_W = 3;
    localparam int IRQ_WORD = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_CLKDET = 2;
    localparam int ST_EXT_CLK = 0;
    localparam int ST_PENDING = 1;
    localparam int ST_SETTLING = 2;
    localparam int ST_DET_DONE = 3;
    // ----------------------------------------------------------------
    // filter and timing
    // ----------------------------------------------------------------
    localparam int SINC_ORDER = 4;
    localparam int RATIO_W = 21;
    localparam int ACC_W = SINC_ORDER * RATIO_W + 1;
    localparam int SETTLE_PERIODS = 4;
    localparam int SHIFT_BITS = 24;
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int NOM_CONV_HZ = 4_915_200;
    localparam int INT_DIV = CLK_FREQ_HZ / NOM_CONV_HZ;
    localparam int DETECT_TIME_US = 100;
    localparam int DETECT_CYC = DETECT_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int EXT_MIN_HZ = 300_000;
    localparam int DETECT_EDGES = (EXT_MIN_HZ / 1000) * DETECT_TIME_US / 1000;
    typedef enum logic [1:0] {AWR_DETECT, AWR_RUN_INT, AWR_RUN_EXT} awr_clk_e;
endpackage

/* awr_ctrl.sv */
// Purpose: rate decode, sinc4 decimator, settling, ready/data shifter and clock select
// Assumes: serial pins and clock pin arrive unsynchronised; mod_bit is pclk-domain logic
// Notes: registers on APB, zero wait states, pslverr on unmapped addresses
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module awr_ctrl #(
    parameter int DETECT_CYCLES = awr_pkg::DETECT_CYC,
    parameter logic [4:0] CODE_100 = 5'h0B,
    parameter logic [4:0] CODE_200 = 5'h0C
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [awr_pkg::ADDR_W-1:0] paddr,
    input wire logic [awr_pkg::DATA_W-1:0] pwdata,
    output logic [awr_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mod_bit,
    input wire logic crystal_or_clock_in,
    output logic crystal_drive_out,
    output logic int_osc_enable,
    output logic [awr_pkg::MUX_W-1:0] mux_select,
    output logic [awr_pkg::GAIN_W-1:0] gain_amplifier,
    output logic filter_reset,
    input wire logic serial_clk,
    input wire logic chip_select,
    output logic data_out_ready_n,
    output logic irq
);
    import awr_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [RATIO_W-1:0] rate_ratio(input logic [RATE_W-1:0] code);
        logic [RATIO_W-1:0] r;
        r = 21'd1229;
        if (code == CODE_100) begin
            r = 21'd49152;
        end else if (code == CODE_200) begin
            r = 21'd24576;
        end else begin
            case (code)
                5'h00: r = 21'd1966080;
                5'h01: r = 21'd983040;
                5'h02: r = 21'd491520;
                5'h03: r = 21'd245760;
                5'h04: r = 21'd122880;
                5'h05: r = 21'd61440;
                5'h06: r = 21'd30720;
                5'h07: r = 21'd15360;
                5'h08: r = 21'd7680;
                5'h09: r = 21'd3840;
                5'h0A: r = 21'd1920;
                5'h0D: r = 21'd12288;
                5'h0E: r = 21'd6144;
                5'h0F: r = 21'd3072;
                5'h10: r = 21'd1536;
                5'h11: r = 21'd4915;
                5'h12: r = 21'd2458;
                default: r = 21'd1229;
            endcase
        end
        return r;
    endfunction

    function automatic logic [6:0] ratio_shift(input logic [RATIO_W-1:0] r);
        logic [4:0] lg;
        lg = 5'd0;
        for (int i = 0; i < RATIO_W; i++) begin
            if (r > (21'd1 << i)) begin
                lg = 5'(i + 1);
            end
        end
        return 7'(SINC_ORDER * lg);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] xin_sync_ff, sclk_sync_ff, cs_sync_ff;
    logic xin_ff, sclk_ff, cs_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xin_sync_ff <= 3'h0;
            sclk_sync_ff <= 3'h0;
            cs_sync_ff <= 3'h0;
            xin_ff <= 1'b0;
            sclk_ff <= 1'b0;
            cs_ff <= 1'b0;
        end else begin
            xin_sync_ff <= {xin_sync_ff[1:0], crystal_or_clock_in};
            sclk_sync_ff <= {sclk_sync_ff[1:0], serial_clk};
            cs_sync_ff <= {cs_sync_ff[1:0], chip_select};
            if (xin_sync_ff[1] == xin_sync_ff[2]) xin_ff <= xin_sync_ff[2];
            if (sclk_sync_ff[1] == sclk_sync_ff[2]) sclk_ff <= sclk_sync_ff[2];
            if (cs_sync_ff[1] == cs_sync_ff[2]) cs_ff <= cs_sync_ff[2];
        end
    end
    wire xin_rise = (xin_sync_ff[1] == xin_sync_ff[2]) && xin_sync_ff[2] && !xin_ff;
    wire sclk_rise = (sclk_sync_ff[1] == sclk_sync_ff[2]) && sclk_sync_ff[2] && !sclk_ff;
    wire cs_fall = (cs_sync_ff[1] == cs_sync_ff[2]) && !cs_sync_ff[2] && cs_ff;

    // ----------------------------------------------------------------
    // clock presence detect and source select
    // ----------------------------------------------------------------
    awr_clk_e clk_state_ff;
    logic [31:0] det_cnt_ff;
    logic [15:0] edge_cnt_ff;
    logic [7:0] div_cnt_ff;
    wire det_end = (clk_state_ff == AWR_DETECT) && (det_cnt_ff == 32'(DETECT_CYCLES - 1));
    wire ext_ok = edge_cnt_ff > 16'(DETECT_EDGES);
    wire div_wrap = div_cnt_ff == 8'(INT_DIV - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_state_ff <= AWR_DETECT;
            det_cnt_ff <= 32'h0000_0000;
            edge_cnt_ff <= 16'h0000;
            div_cnt_ff <= 8'h00;
        end else begin
            div_cnt_ff <= div_wrap ? 8'h00 : div_cnt_ff + 8'h01;
            case (clk_state_ff)
                AWR_DETECT: begin
                    det_cnt_ff <= det_cnt_ff + 32'h0000_0001;
                    if (xin_rise && edge_cnt_ff != 16'hFFFF) edge_cnt_ff <= edge_cnt_ff + 16'h0001;
                    if (det_end) clk_state_ff <= ext_ok ? AWR_RUN_EXT : AWR_RUN_INT;
                end
                AWR_RUN_INT: clk_state_ff <= AWR_RUN_INT;
                AWR_RUN_EXT: clk_state_ff <= AWR_RUN_EXT;
                default: clk_state_ff <= AWR_DETECT;
            endcase
        end
    end
    wire src_ext = clk_state_ff == AWR_RUN_EXT;
    // converter tick from external pin edges or the internal divider; rate scales with it
    wire conv_tick = src_ext ? xin_rise : (clk_state_ff == AWR_RUN_INT) && div_wrap;
    assign int_osc_enable = !src_ext;
    // crystal inverter drive stays off unless the pin is proven to oscillate
    assign crystal_drive_out = src_ext && !xin_ff;

    // ----------------------------------------------------------------
    // registers over apb
    // ----------------------------------------------------------------
    logic [CONV_W-1:0] conv_ff;
    logic [RATE_W-1:0] rate_ff;
    logic [MUX_W-1:0] mux_ff;
    logic [GAIN_W-1:0] gain_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
    logic [WORD_W-1:0] data_ff;
    logic [IRQ_W-1:0] irq_set;
    logic word_ready_ff, settling;
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    wire hit_conv = paddr == ADDR_CONV_CTRL;
    wire hit_rate = paddr == ADDR_WORD_RATE;
    wire hit_mux = paddr == ADDR_MUX_SEL;
    wire hit_gain = paddr == ADDR_GAIN_SEL;
    wire hit_stat = paddr == ADDR_STATUS;
    wire hit_data = paddr == ADDR_DATA;
    wire hit_ist = paddr == ADDR_IRQ_STAT;
    wire hit_imsk = paddr == ADDR_IRQ_MASK;
    wire mapped = hit_conv | hit_rate | hit_mux | hit_gain | hit_stat | hit_data | hit_ist
                  | hit_imsk;
    wire wr_conv = wr && hit_conv;
    wire wr_rate = wr && hit_rate && pwdata[RATE_W-1:0] <= RATE_MAX_CODE;
    wire wr_mux = wr && hit_mux;
    wire wr_gain = wr && hit_gain;
    wire start_cmd = wr_conv && pwdata[CONV_W-1:0] != CONV_IDLE;
    wire single_done;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    wire [DATA_W-1:0] status_word = {28'h000_0000, clk_state_ff != AWR_DETECT, settling,
                                     word_ready_ff, src_ext};
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (1'b1)
                hit_conv: prdata = {30'h0000_0000, conv_ff};
                hit_rate: prdata = {27'h000_0000, rate_ff};
                hit_mux: prdata = {29'h0000_0000, mux_ff};
                hit_gain: prdata = {29'h0000_0000, gain_ff};
                hit_stat: prdata = status_word;
                hit_data: prdata = {8'h00, data_ff};
                hit_ist: prdata = {29'h0000_0000, irq_stat_ff};
                hit_imsk: prdata = {29'h0000_0000, irq_mask_ff};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_ff <= CONV_IDLE;
            rate_ff <= RATE_RST;
            mux_ff <= 3'h0;
            gain_ff <= 3'h0;
            irq_mask_ff <= 3'h0;
            irq_stat_ff <= 3'h0;
        end else begin
            if (wr_conv) conv_ff <= pwdata[CONV_W-1:0];
            else if (single_done) conv_ff <= CONV_IDLE;
            if (wr_rate) rate_ff <= pwdata[RATE_W-1:0];
            if (wr_mux) mux_ff <= pwdata[MUX_W-1:0];
            if (wr_gain) gain_ff <= pwdata[GAIN_W-1:0];
            if (wr && hit_imsk) irq_mask_ff <= pwdata[IRQ_W-1:0];
            // a new event wins over a write-one-to-clear in the same cycle
            irq_stat_ff <= (irq_stat_ff & ~((wr && hit_ist) ? pwdata[IRQ_W-1:0] : 3'h0)) | irq_set;
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);
    assign mux_select = mux_ff;
    assign gain_amplifier = gain_ff;

    // ----------------------------------------------------------------
    // sinc4 decimator and settling
    // ----------------------------------------------------------------
    logic [ACC_W-1:0] integ_ff [SINC_ORDER];
    logic [ACC_W-1:0] dly_ff [SINC_ORDER];
    logic [ACC_W-1:0] comb [SINC_ORDER+1];
    logic [RATIO_W-1:0] dec_cnt_ff;
    logic [2:0] settle_ff;
    wire running = conv_ff != CONV_IDLE;
    wire restart = wr_mux || wr_gain || start_cmd || wr_rate;
    assign filter_reset = restart || !running;
    wire [RATIO_W-1:0] ratio = rate_ratio(rate_ff);
    wire dec_point = conv_tick && dec_cnt_ff == ratio - 21'd1;
    assign settling = settle_ff != 3'(SETTLE_PERIODS - 1);
    wire word_out = dec_point && !settling;
    assign comb[0] = integ_ff[SINC_ORDER-1];
    genvar g;
    generate
        for (g = 0; g < SINC_ORDER; g++) begin : g_stage
            assign comb[g+1] = comb[g] - dly_ff[g];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    integ_ff[g] <= '0;
                    dly_ff[g] <= '0;
                end else if (filter_reset) begin
                    integ_ff[g] <= '0;
                    dly_ff[g] <= '0;
                end else begin
                    if (conv_tick) begin
                        integ_ff[g] <= integ_ff[g] + ((g == 0) ? ACC_W'(mod_bit)
                                                               : integ_ff[(g == 0) ? 0 : g-1]);
                    end
                    if (dec_point) dly_ff[g] <= comb[g];
                end
            end
        end
    endgenerate
    // an all-ones stream settles near ratio^4; taking off half of it gives a signed word
    wire [ACC_W-1:0] ratio_ext = ACC_W'(ratio);
    wire [ACC_W-1:0] full_scale = ratio_ext * ratio_ext * ratio_ext * ratio_ext;
    wire [ACC_W-1:0] centred = comb[SINC_ORDER] - (full_scale >> 1);
    // half scale stays under the top bit after this shift, so the sign survives
    wire [6:0] shl = 7'(ACC_W) - ratio_shift(ratio);
    wire [ACC_W-1:0] scaled = centred << shl;
    wire [WORD_W-1:0] new_word = scaled[ACC_W-1 -: WORD_W];
    assign single_done = word_out && conv_ff == CONV_SINGLE && !wr_conv;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_cnt_ff <= '0;
            settle_ff <= 3'h0;
            data_ff <= 24'h00_0000;
        end else if (filter_reset) begin
            dec_cnt_ff <= '0;
            settle_ff <= 3'h0;
        end else begin
            if (conv_tick) dec_cnt_ff <= dec_point ? '0 : dec_cnt_ff + 21'd1;
            if (dec_point && settling) settle_ff <= settle_ff + 3'h1;
            if (word_out) data_ff <= new_word;
        end
    end

    // ----------------------------------------------------------------
    // ready/data shifter
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] shreg_ff;
    logic [4:0] bit_cnt_ff;
    logic sdo_ff;
    wire shifting = word_ready_ff && cs_ff && sclk_rise && bit_cnt_ff != 5'(SHIFT_BITS);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_ready_ff <= 1'b0;
            shreg_ff <= 24'h00_0000;
            bit_cnt_ff <= 5'h00;
            sdo_ff <= 1'b1;
        end else if (word_out) begin
            word_ready_ff <= 1'b1;
            shreg_ff <= new_word;
            bit_cnt_ff <= 5'h00;
            sdo_ff <= 1'b0;
        end else if (shifting) begin
            sdo_ff <= shreg_ff[WORD_W-1];
            shreg_ff <= {shreg_ff[WORD_W-2:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end else if (cs_fall && bit_cnt_ff != 5'h00) begin
            word_ready_ff <= 1'b0;
            sdo_ff <= 1'b1;
        end
    end
    // the line only signals while select is high; otherwise it idles high
    assign data_out_ready_n = (cs_ff && word_ready_ff) ? sdo_ff : 1'b1;
    assign irq_set = {det_end,
                      word_out && word_ready_ff && bit_cnt_ff != 5'(SHIFT_BITS),
                      word_out};
endmodule

/* awr_checker.sv */
// Purpose: port-level checks for awr_ctrl
// Assumes: one pclk domain, async active-low reset
// Notes: settle bound assumes ticks at least two pclk apart
`timescale 1ns/1ps
module awr_checker #(
    parameter int DETECT_CYCLES = 10000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [awr_pkg::ADDR_W-1:0] paddr,
    input wire logic [awr_pkg::DATA_W-1:0] pwdata,
    input wire logic pslverr,
    input wire logic int_osc_enable,
    input wire logic crystal_drive_out,
    input wire logic [awr_pkg::MUX_W-1:0] mux_select,
    input wire logic filter_reset,
    input wire logic serial_clk,
    input wire logic chip_select,
    input wire logic data_out_ready_n
);
    import awr_pkg::*;
    // four periods of the fastest ratio, ticks no closer than two pclk
    localparam int MIN_SETTLE = 9832;
    logic [15:0] up_ff;
    logic [15:0] since_ff;
    logic [3:0] quiet_ff;
    logic sclk_ff;
    wire logic acc_wr = psel && penable && pwrite;
    wire logic wr_mux = acc_wr && paddr == ADDR_MUX_SEL;
    wire logic restart = acc_wr && (paddr == ADDR_MUX_SEL || paddr == ADDR_GAIN_SEL
        || (paddr == ADDR_WORD_RATE && pwdata[RATE_W-1:0] <= RATE_MAX_CODE)
        || (paddr == ADDR_CONV_CTRL && pwdata[CONV_W-1:0] != CONV_IDLE));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff <= '0;
            since_ff <= '0;
            quiet_ff <= '0;
            sclk_ff <= 1'b0;
        end else begin
            up_ff <= up_ff + 16'(up_ff != 16'hffff);
            since_ff <= restart ? '0 : since_ff + 16'(since_ff != 16'hffff);
            quiet_ff <= (serial_clk != sclk_ff) ? '0 : quiet_ff + 4'(quiet_ff != 4'hf);
            sclk_ff <= serial_clk;
        end
    end
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_mux_from_write: assert property (
        wr_mux |=> mux_select == MUX_W'($past(pwdata))) else $error("mux select missed write");
    chk_restart_flush: assert property (wr_mux |-> filter_reset)
        else $error("filter not reset on channel write");
    // a fall with the serial clock quiet is a ready flag, not a data bit
    chk_settle_hold: assert property (
        $fell(data_out_ready_n) && quiet_ff > 4'h5 |-> since_ff >= MIN_SETTLE)
        else $error("word ready before filter settled");
    chk_ready_needs_cs: assert property (!chip_select [*8] |-> data_out_ready_n)
        else $error("ready line low without chip select");
    chk_osc_in_detect: assert property (up_ff < DETECT_CYCLES |-> int_osc_enable)
        else $error("oscillator off during detection");
    chk_osc_held: assert property (up_ff > DETECT_CYCLES + 8 |-> $stable(int_osc_enable))
        else $error("clock source changed after detection");
    chk_xtal_idle: assert property (int_osc_enable |-> !crystal_drive_out)
        else $error("crystal drive active on internal clock");
    chk_unmapped_err: assert property (psel && penable && paddr > ADDR_IRQ_MASK |-> pslverr)
        else $error("no error on unmapped address");
    cover property (restart);
    cover property ($fell(data_out_ready_n) && quiet_ff > 4'h5);
    cover property ($fell(int_osc_enable));
endmodule

bind awr_ctrl awr_checker #(.DETECT_CYCLES(DETECT_CYCLES)) i_awr_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .int_osc_enable(int_osc_enable),
    .crystal_drive_out(crystal_drive_out), .mux_select(mux_select),
    .filter_reset(filter_reset), .serial_clk(serial_clk), .chip_select(chip_select),
    .data_out_ready_n(data_out_ready_n));

/* awr_host.sv */
// Purpose: host side of the serial read port
// Assumes: link clock period 160 ns, made only inside a frame
// Notes: input held steady by the bench, so every word is trusted
`timescale 1ns/1ps
module awr_host (
    output logic serial_clk,
    output logic chip_select,
    input wire logic data_out_ready_n
);
    // every shifted word is taken as read; stimulus never steps mid-run
    initial begin
        serial_clk = 1'b0;
        chip_select = 1'b0;
    end
    // pin moves are kept off the pclk edges so the synchroniser never races them
    task automatic select();
        #2;
        chip_select = 1'b1;
    endtask
    // bit taken late in the high phase, after the device has moved it
    task automatic shift_word(output logic [23:0] w);
        w = '0;
        #2;
        for (int i = 0; i < 24; i++) begin
            serial_clk = 1'b1;
            #70;
            w = {w[22:0], data_out_ready_n};
            #10;
            serial_clk = 1'b0;
            #80;
        end
        chip_select = 1'b0;
        #80;
    endtask
endmodule

/* testbench.sv */
// Purpose: self-checking bench for awr_ctrl with a host model
// Assumes: clock pin near 14 MHz once enabled; fastest rate code
// Notes: detection window shortened; settling sets the run time
`timescale 1ns/1ps
module testbench;
    import awr_pkg::*;
    localparam int DET = 400;
    localparam int R = 1229;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic mod_bit = 1'b0;
    logic xin = 1'b0;
    logic xrun = 1'b0;
    logic pready, pslverr, xout, osc_en, filt_rst, sclk, cs, dor_n, irq, err;
    logic [DATA_W-1:0] prdata, rd;
    logic [MUX_W-1:0] mux;
    logic [GAIN_W-1:0] gain;
    logic [23:0] w;
    logic [31:0] st = 32'h0000_d508;
    logic [31:0] msk[8] = '{32'h3, 32'h1f, 32'h7, 32'h7, 32'h0, 32'h0, 32'h0, 32'h7};
    int model[8];
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int ticks = 0;
    int t0 = 0;
    always #5 pclk = ~pclk;
    always #35.3 xin = xrun ? ~xin : 1'b0;
    always @(posedge xin) ticks++;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_fail++;
            results();
        end
    end
    awr_ctrl #(.DETECT_CYCLES(DET)) i_awr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit), .crystal_or_clock_in(xin),
        .crystal_drive_out(xout), .int_osc_enable(osc_en), .mux_select(mux),
        .gain_amplifier(gain), .filter_reset(filt_rst), .serial_clk(sclk), .chip_select(cs),
        .data_out_ready_n(dor_n), .irq(irq));
    awr_host i_awr_host (.serial_clk(sclk), .chip_select(cs), .data_out_ready_n(dor_n));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (wr && !err && msk[a[4:2]] != 0 && !(a == ADDR_WORD_RATE && d > 32'h13)) begin
            model[a[4:2]] = d & msk[a[4:2]];
        end
    endtask
    task automatic rdchk(input logic [7:0] a);
        apb(1'b0, a, '0);
        check(rd, model[a[4:2]]);
    endtask
    // t0 is set by the caller at the start of the conversion
    task automatic wait_word(input int per);
        int n;
        n = 0;
        while (dor_n !== 1'b0 && n < 60000) begin
            n++;
            @(posedge pclk);
        end
        check(32'(ticks - t0 >= per - 3 && ticks - t0 <= per + 3), 1);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) if (msk[i] != 0) rdchk(8'(i * 4));
        apb(1'b0, 8'h20, '0);
        check(32'(err), 1);
        repeat (DET + 100) @(posedge pclk);
        check(32'(osc_en), 1);
        check(32'(xout), 0);
        check(32'(filt_rst), 1);
        apb(1'b0, ADDR_STATUS, '0);
        check(rd & 32'h9, 32'h8);
        for (int c = 0; c < 22; c++) begin
            apb(1'b1, ADDR_WORD_RATE, 32'(c));
            rdchk(ADDR_WORD_RATE);
        end
        repeat (4) begin
            st = xs(st);
            mod_bit <= st[0];
            apb(1'b1, ADDR_MUX_SEL, st & 32'h7);
            apb(1'b1, ADDR_GAIN_SEL, (st >> 8) & 32'h7);
            rdchk(ADDR_MUX_SEL);
            check(32'(mux), model[2]);
            check(32'(gain), model[3]);
        end
        xrun = 1'b1;
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        model = '{default: 0};
        repeat (DET + 100) @(posedge pclk);
        check(32'(osc_en), 0);
        apb(1'b0, ADDR_STATUS, '0);
        check(rd & 32'h9, 32'h9);
        mod_bit <= 1'b1;
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        apb(1'b1, ADDR_WORD_RATE, 32'h13);
        i_awr_host.select();
        apb(1'b1, ADDR_CONV_CTRL, 32'h1);
        t0 = ticks;
        wait_word(4 * R);
        model[0] = 0;
        rdchk(ADDR_CONV_CTRL);
        check(32'(irq), 1);
        i_awr_host.shift_word(w);
        apb(1'b0, ADDR_DATA, '0);
        check(32'(w), rd & 32'hff_ffff);
        check(32'(w[23]), 0);
        check(32'(dor_n), 1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        apb(1'b0, ADDR_IRQ_STAT, '0);
        check(rd & 32'h7, 32'h4);
        check(32'(irq), 0);
        apb(1'b1, ADDR_IRQ_MASK, '0);
        mod_bit <= 1'b0;
        i_awr_host.select();
        apb(1'b1, ADDR_CONV_CTRL, 32'h2);
        t0 = ticks;
        wait_word(4 * R);
        check(32'(irq), 0);
        i_awr_host.shift_word(w);
        check(32'(w[23]), 1);
        i_awr_host.select();
        wait_word(5 * R);
        rdchk(ADDR_CONV_CTRL);
        apb(1'b0, ADDR_IRQ_STAT, '0);
        check(rd & 32'h7, 32'h5);
        apb(1'b1, ADDR_CONV_CTRL, '0);
        results();
    end
endmodule
